// *** design/gpwi_consts.svh ***
// gpwi_consts.svh: widths, field positions and reset values of the pin port
// assumes: included by bare name from package and design files
`ifndef GPWI_CONSTS_SVH
`define GPWI_CONSTS_SVH

`define GPWI_NPINS        21
`define GPWI_WORD_W       32
`define GPWI_BYTE_W       8
`define GPWI_LOW_GRP_LSB  0
`define GPWI_HIGH_GRP_LSB 8
`define GPWI_DIR_RST      21'h000000
`define GPWI_OUT_RST      21'h000000
`define GPWI_PULL_RST     21'h1fffff
`define GPWI_EDGE_RST     21'h000000
`define GPWI_EN_RST       21'h000000

`endif

// *** design/gpwi_pkg.sv ***
// gpwi_pkg.sv: types shared by the pin port files
// assumes: gpwi_consts.svh on the include path
`include "gpwi_consts.svh"

package gpwi_pkg;

  typedef logic [`GPWI_NPINS-1:0] gpwi_pins_t;

  typedef enum logic [0:0] {
    GPWI_GRP_LOW  = 1'b0,
    GPWI_GRP_HIGH = 1'b1
  } gpwi_grp_t;

  // per-pin wake/interrupt controls, one storage for both views
  typedef struct packed {
    gpwi_pins_t edge_fall;
    gpwi_pins_t enable;
  } gpwi_evt_cfg_t;

  // per-pin drive to the pad
  typedef struct packed {
    gpwi_pins_t out;
    gpwi_pins_t oe;
    gpwi_pins_t pull_en;
  } gpwi_pad_t;

  typedef enum logic [1:0] {
    GPWI_PWR_RUN   = 2'b00,
    GPWI_PWR_DOZE  = 2'b01,
    GPWI_PWR_SLEEP = 2'b10,
    GPWI_PWR_DEEP  = 2'b11
  } gpwi_pwr_t;

endpackage

// *** design/gpwi_sync.sv ***
// gpwi_sync.sv: two-flop synchroniser for a vector of pad levels
// assumes: inputs asynchronous to clock, outputs read by logic on clock
`timescale 1ns/100ps
`default_nettype none

module gpwi_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         srst,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// *** design/gpwi_edge.sv ***
// gpwi_edge.sv: per-pin edge detect and sticky status bit
// assumes: level already synchronised to clock
`timescale 1ns/100ps
`default_nettype none

module gpwi_edge (
  // clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // pin level and controls
  input  wire logic level,
  input  wire logic edge_fall,
  input  wire logic is_input,
  input  wire logic clr,
  // results
  output logic      hit,
  output logic      status
);

  logic prev_q;
  logic prev_d;
  logic stat_q;
  logic stat_d;

  always_comb begin
    prev_d = level;
    hit    = is_input && (edge_fall ? (prev_q && !level) : (!prev_q && level));
    // set beats clear in the same cycle
    stat_d = hit || (stat_q && !clr);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prev_q <= 1'b1;
      stat_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      stat_q <= stat_d;
    end
  end

  assign status = stat_q;

endmodule

`default_nettype wire

// *** design/gpwi_port.sv ***
// gpwi_port.sv: 21-pin general io port with pull-ups, byte groups, edge wake
// assumes: one 25 MHz clock, srst synchronous; pad wire resolved outside
//
// Contract
// - 21 pins, each input or output
// - enabled peripheral takes over its pin
// - reset: peripherals off, all pins input
// - direction stored, applied once peripheral off
// - 32-bit output word, bits 21-31 ignored
// - outputs held for inputs, driven later
// - output value held while peripheral owns
// - byte write to low/high group
// - byte read from one 8-pin group
// - per-pin pull-up, all on at reset
// - pull-up holds under peripheral, not crystal
// - pull-up kept and active in sleep
// - read word shows every pin level
// - edge select rising or falling, rising default
// - per-pin enable, inputs only raise events
// - status records edges even when disabled
// - interrupt and wake views share bits
// - enabled edge wakes from sleep or doze
// - wake edge rising default, per-pin enable
// - status kept until cleared per pin or all at initialisation
// - events go to system controller line
`timescale 1ns/100ps
`default_nettype none
`include "gpwi_consts.svh"

module gpwi_port (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       srst,
  // direction, output and pull-up writes
  input  wire logic                       dir_wr,
  input  wire logic [`GPWI_NPINS-1:0]     dir_wdata,
  input  wire logic                       out_wr,
  input  wire logic [`GPWI_WORD_W-1:0]    out_wdata,
  input  wire logic                       pull_wr,
  input  wire logic [`GPWI_NPINS-1:0]     pull_wdata,
  // byte group access
  input  wire logic                       byte_wr,
  input  wire gpwi_pkg::gpwi_grp_t        byte_wr_grp,
  input  wire logic [`GPWI_BYTE_W-1:0]    byte_wdata,
  input  wire gpwi_pkg::gpwi_grp_t        byte_rd_grp,
  output logic      [`GPWI_BYTE_W-1:0]    byte_rdata,
  output logic                            byte_grp_ok,
  // edge and enable, written through interrupt or wake view
  input  wire logic                       int_edge_wr,
  input  wire logic                       wake_edge_wr,
  input  wire logic [`GPWI_NPINS-1:0]     edge_wdata,
  input  wire logic                       int_en_wr,
  input  wire logic                       wake_en_wr,
  input  wire logic [`GPWI_NPINS-1:0]     en_wdata,
  input  wire logic [`GPWI_NPINS-1:0]     status_clr,
  input  wire logic                       init_clr_all,
  // state read back
  output logic      [`GPWI_WORD_W-1:0]    pin_state,
  output logic      [`GPWI_WORD_W-1:0]    evt_status,
  output gpwi_pkg::gpwi_evt_cfg_t         evt_cfg,
  output logic      [`GPWI_NPINS-1:0]     dir_out,
  output logic      [`GPWI_NPINS-1:0]     out_value,
  // system controller side
  input  wire gpwi_pkg::gpwi_pwr_t        pwr_state,
  output logic                            sysctl_irq,
  output logic                            wake_req,
  // peripheral sharing
  input  wire logic [`GPWI_NPINS-1:0]     periph_own,
  input  wire logic [`GPWI_NPINS-1:0]     periph_out,
  input  wire logic [`GPWI_NPINS-1:0]     periph_oe,
  input  wire logic [`GPWI_NPINS-1:0]     xtal_pin,
  output logic      [`GPWI_NPINS-1:0]     periph_in,
  // pads
  input  wire logic [`GPWI_NPINS-1:0]     general_io_pin_i,
  output logic      [`GPWI_NPINS-1:0]     general_io_pin_o,
  output logic      [`GPWI_NPINS-1:0]     general_io_pin_oe,
  output logic      [`GPWI_NPINS-1:0]     general_io_pin_pu
);

  localparam int N  = `GPWI_NPINS;
  localparam int BW = `GPWI_BYTE_W;

  logic [N-1:0] dir_q;
  logic [N-1:0] dir_d;
  logic [N-1:0] out_q;
  logic [N-1:0] out_d;
  logic [N-1:0] pull_q;
  logic [N-1:0] pull_d;
  gpwi_pkg::gpwi_evt_cfg_t cfg_q;
  gpwi_pkg::gpwi_evt_cfg_t cfg_d;
  gpwi_pkg::gpwi_pad_t     pad_q;
  gpwi_pkg::gpwi_pad_t     pad_d;
  logic [BW-1:0] rbyte_q;
  logic [BW-1:0] rbyte_d;
  logic          grp_ok_q;
  logic          grp_ok_d;
  logic          irq_q;
  logic          irq_d;
  logic          wake_q;
  logic          wake_d;
  logic [N-1:0]  lvl;
  logic [N-1:0]  hit;
  logic [N-1:0]  stat;
  logic [N-1:0]  clr;
  logic [N-1:0]  is_in;
  logic [N-1:0]  in_cfg;
  logic [3:0][N-1:0] drove_q;
  logic [3:0][N-1:0] drove_d;
  logic          asleep;

  // pad levels cross into the clock domain before any use
  gpwi_sync #(.W(N)) u_sync (
    .clock    (clock),
    .srst     (srst),
    .async_in (general_io_pin_i),
    .sync_out (lvl)
  );

  // an owned pin never counts as an input for events
  assign in_cfg = ~dir_q & ~periph_own;
  // a pin just released still shows its own drive for four cycles (pad
  // register, two sync flops and the edge history flop); events wait that long so the port never
  // flags its own output, at the cost of a real edge in that window
  assign is_in  = in_cfg & ~(drove_q[0] | drove_q[1] | drove_q[2] | drove_q[3]);

  always_comb begin
    drove_d = {drove_q[2:0], ~in_cfg};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      drove_q <= {4{`GPWI_DIR_RST}};
    end else begin
      drove_q <= drove_d;
    end
  end
  assign clr   = status_clr | {N{init_clr_all}};

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      gpwi_edge u_edge (
        .clock     (clock),
        .srst      (srst),
        .level     (lvl[g]),
        .edge_fall (cfg_q.edge_fall[g]),
        .is_input  (is_in[g]),
        .clr       (clr[g]),
        .hit       (hit[g]),
        .status    (stat[g])
      );
    end
  endgenerate

  // control store
  always_comb begin
    dir_d  = dir_q;
    out_d  = out_q;
    pull_d = pull_q;
    cfg_d  = cfg_q;
    // stored even for owned pins, takes effect through pad mux
    if (dir_wr) begin
      dir_d = dir_wdata;
    end
    if (out_wr) begin
      out_d = out_wdata[N-1:0];
    end
    if (byte_wr) begin
      if (byte_wr_grp == gpwi_pkg::GPWI_GRP_HIGH) begin
        out_d[`GPWI_HIGH_GRP_LSB +: BW] = byte_wdata;
      end else begin
        out_d[`GPWI_LOW_GRP_LSB +: BW] = byte_wdata;
      end
    end
    if (pull_wr) begin
      pull_d = pull_wdata;
    end
    // both views land in the same bits
    if (int_edge_wr || wake_edge_wr) begin
      cfg_d.edge_fall = edge_wdata;
    end
    if (int_en_wr || wake_en_wr) begin
      cfg_d.enable = en_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dir_q  <= `GPWI_DIR_RST;
      out_q  <= `GPWI_OUT_RST;
      pull_q <= `GPWI_PULL_RST;
      cfg_q  <= {`GPWI_EDGE_RST, `GPWI_EN_RST};
    end else begin
      dir_q  <= dir_d;
      out_q  <= out_d;
      pull_q <= pull_d;
      cfg_q  <= cfg_d;
    end
  end

  // pad drive and read-back
  always_comb begin
    // peripheral wins the pin while it owns it
    pad_d.out     = (periph_own & periph_out) | (~periph_own & out_q);
    pad_d.oe      = (periph_own & periph_oe) | (~periph_own & dir_q);
    // pull stays whatever the power state; crystal pins not pulled while a peripheral owns them
    pad_d.pull_en = pull_q & ~(periph_own & xtal_pin);
    rbyte_d       = (byte_rd_grp == gpwi_pkg::GPWI_GRP_HIGH) ?
                    lvl[`GPWI_HIGH_GRP_LSB +: BW] : lvl[`GPWI_LOW_GRP_LSB +: BW];
    grp_ok_d      = (byte_rd_grp == gpwi_pkg::GPWI_GRP_HIGH) ?
                    (&in_cfg[`GPWI_HIGH_GRP_LSB +: BW]) :
                    (&in_cfg[`GPWI_LOW_GRP_LSB +: BW]);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pad_q    <= {`GPWI_OUT_RST, `GPWI_DIR_RST, `GPWI_PULL_RST};
      rbyte_q  <= 8'h00;
      grp_ok_q <= 1'b1;
    end else begin
      pad_q    <= pad_d;
      rbyte_q  <= rbyte_d;
      grp_ok_q <= grp_ok_d;
    end
  end

  // system controller event and wake
  assign asleep = (pwr_state != gpwi_pkg::GPWI_PWR_RUN);

  always_comb begin
    irq_d  = |(stat & cfg_q.enable);
    wake_d = asleep && (|(hit & cfg_q.enable));
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= irq_d;
      wake_q <= wake_d;
    end
  end

  assign general_io_pin_o  = pad_q.out;
  assign general_io_pin_oe = pad_q.oe;
  assign general_io_pin_pu = pad_q.pull_en;
  assign periph_in         = lvl;
  assign pin_state         = {{(`GPWI_WORD_W-N){1'b0}}, lvl};
  assign evt_status        = {{(`GPWI_WORD_W-N){1'b0}}, stat};
  assign evt_cfg           = cfg_q;
  assign dir_out           = dir_q;
  assign out_value         = out_q;
  assign byte_rdata        = rbyte_q;
  assign byte_grp_ok       = grp_ok_q;
  assign sysctl_irq        = irq_q;
  assign wake_req          = wake_q;

endmodule

`default_nettype wire

// *** dv/gpwi_pads_model.sv ***
// gpwi_pads_model.sv: far-side signals on the general io pads
// assumes: bench drives ext_drv/ext_val, never against a pin the port drives
`timescale 1ns/100ps
`default_nettype none

module gpwi_pads_model (
  // clock
  input  wire logic        clock,
  // port drive
  input  wire logic [20:0] general_io_pin_o,
  input  wire logic [20:0] general_io_pin_oe,
  input  wire logic [20:0] general_io_pin_pu,
  // far-side drivers
  input  wire logic [20:0] ext_drv,
  input  wire logic [20:0] ext_val,
  output logic      [20:0] general_io_pin_i
);
  logic [20:0] float_q = 21'h0;

  // a floating pin wanders, so a stale level never passes as a real one
  always_ff @(posedge clock) begin
    float_q <= ~float_q;
  end

  assign general_io_pin_i = general_io_pin_oe & general_io_pin_o
    | ~general_io_pin_oe & (ext_drv & ext_val | ~ext_drv & (general_io_pin_pu | float_q));
endmodule

`default_nettype wire

// *** dv/gpwi_port_assertions.sv ***
// gpwi_port_assertions.sv: timing checks on the pin port
// assumes: bound onto gpwi_port, single clock, srst synchronous
`timescale 1ns/100ps
`default_nettype none

module gpwi_port_assertions (
  // clock and reset
  input wire logic                    clock,
  input wire logic                    srst,
  // writes
  input wire logic                    dir_wr,
  input wire logic [20:0]             dir_wdata,
  input wire logic                    out_wr,
  input wire logic [31:0]             out_wdata,
  input wire logic                    byte_wr,
  input wire logic                    pull_wr,
  input wire logic [20:0]             pull_wdata,
  input wire logic [20:0]             status_clr,
  input wire logic                    init_clr_all,
  // state and events
  input wire logic [31:0]             pin_state,
  input wire logic [31:0]             evt_status,
  input wire gpwi_pkg::gpwi_evt_cfg_t evt_cfg,
  input wire logic [20:0]             dir_out,
  input wire logic [20:0]             out_value,
  input wire gpwi_pkg::gpwi_pwr_t     pwr_state,
  input wire logic                    sysctl_irq,
  input wire logic                    wake_req,
  // sharing and pads
  input wire logic [20:0]             periph_own,
  input wire logic [20:0]             periph_out,
  input wire logic [20:0]             periph_oe,
  input wire logic [20:0]             xtal_pin,
  input wire logic [20:0]             general_io_pin_i,
  input wire logic [20:0]             general_io_pin_o,
  input wire logic [20:0]             general_io_pin_oe,
  input wire logic [20:0]             general_io_pin_pu
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [20:0] own_xtal;
  assign own_xtal = periph_own & xtal_pin;

  chk_dir_store:
    assert property (dir_wr |=> dir_out == $past(dir_wdata)) else $error("direction lost");
  chk_out_store:
    assert property (out_wr && !byte_wr |=> out_value == $past(out_wdata[20:0]))
      else $error("output word lost");
  chk_pad_enable:
    assert property (!$past(srst) |-> general_io_pin_oe
      == $past(periph_own & periph_oe | ~periph_own & dir_out)) else $error("pad enable wrong");
  chk_pad_value:
    assert property (!$past(srst) |-> general_io_pin_o
      == $past(periph_own & periph_out | ~periph_own & out_value)) else $error("pad value wrong");
  chk_pull_apply:
    assert property (pull_wr |=> ##1 general_io_pin_pu == ($past(pull_wdata, 2) & ~$past(own_xtal)))
      else $error("pull-up wrong");
  chk_pin_sync:
    assert property (!$past(srst) && !$past(srst, 2) |-> pin_state[20:0] == $past(general_io_pin_i, 2))
      else $error("pin level wrong");
  chk_status_sticky:
    assert property (!init_clr_all |=> &(evt_status[20:0] | ~$past(evt_status[20:0] & ~status_clr)))
      else $error("status dropped");
  chk_irq_level:
    assert property (!$past(srst) |-> sysctl_irq == |$past(evt_status[20:0] & evt_cfg.enable))
      else $error("irq wrong");
  chk_wake_cause:
    assert property (wake_req |-> $past(pwr_state) != gpwi_pkg::GPWI_PWR_RUN
      && |(evt_status[20:0] & $past(evt_cfg.enable))) else $error("wake without cause");
  chk_upper_zero:
    assert property (pin_state[31:21] == 11'h0 && evt_status[31:21] == 11'h0)
      else $error("upper bits set");
endmodule

`default_nettype wire

// *** dv/test_gpwi_port.sv ***
// test_gpwi_port.sv: self-checking bench for the pin port
// assumes: pad model and checker compiled before this file
`timescale 1ns/100ps
`default_nettype none

module test_gpwi_port;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [8:0] wr_q = 9'h0;
  logic [20:0] dir_wdata = '0, pull_wdata = '0, edge_wdata = '0, en_wdata = '0, status_clr = '0;
  logic [20:0] periph_own = '0, periph_out = '0, periph_oe = '0, xtal_pin = '0;
  logic [20:0] ext_drv = '0, ext_val = '0;
  logic [31:0] out_wdata = '0;
  logic [7:0] byte_wdata = '0;
  gpwi_pkg::gpwi_grp_t byte_wr_grp = gpwi_pkg::GPWI_GRP_LOW, byte_rd_grp = gpwi_pkg::GPWI_GRP_LOW;
  gpwi_pkg::gpwi_pwr_t pwr_state = gpwi_pkg::GPWI_PWR_RUN;
  wire logic dir_wr, out_wr, pull_wr, byte_wr, int_edge_wr, wake_edge_wr, int_en_wr, wake_en_wr;
  wire logic init_clr_all;
  logic byte_grp_ok, sysctl_irq, wake_req;
  logic [7:0] byte_rdata;
  logic [20:0] dir_out, out_value, periph_in;
  logic [20:0] general_io_pin_i, general_io_pin_o, general_io_pin_oe, general_io_pin_pu;
  logic [31:0] pin_state, evt_status;
  gpwi_pkg::gpwi_evt_cfg_t evt_cfg;
  int failures = 0;
  int compares = 0;

  assign {init_clr_all, wake_en_wr, int_en_wr, wake_edge_wr, int_edge_wr, byte_wr, pull_wr, out_wr,
          dir_wr} = wr_q;
  always #20 clock = ~clock;

  gpwi_port gpwi_port_i (.*);
  gpwi_pads_model gpwi_pads_model_i (.*);

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // strobe bit k for one edge: 0 dir 1 out 2 pull 3 byte 5 wake edge 6 irq en 7 wake en 8 init
  task automatic pulse(input int k);
    @(posedge clock);
    wr_q <= 9'h001 << k;
    @(posedge clock);
    wr_q <= 9'h0;
    #1;
  endtask

  task automatic chk(input string what, input logic [41:0] seen, input logic [41:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic t_out;
    chk("dir_out", dir_out, 21'h0);
    chk("pad_pu", general_io_pin_pu, 21'h1fffff);
    chk("evt_cfg", evt_cfg, 42'h0);
    out_wdata <= 32'hffe0_0005;
    pulse(1);
    tick(2);
    chk("out_value", out_value, 21'h5);
    chk("pad_oe", general_io_pin_oe, 21'h0);
    dir_wdata <= 21'h5;
    pulse(0);
    tick(2);
    chk("pad_out", general_io_pin_o & 21'h5, 21'h5);
    out_wdata <= 32'h0;
    pulse(1);
    out_wdata <= 32'h5;
    pulse(1);
    tick(6);
    chk("evt_status", evt_status, 32'h0);
    $display("test output done");
  endtask

  task automatic t_periph;
    periph_own <= 21'h4;
    periph_oe <= 21'h4;
    periph_out <= 21'h4;
    dir_wdata <= 21'h4;
    out_wdata <= 32'h0;
    pulse(1);
    pulse(0);
    tick(2);
    chk("dir_out", dir_out, 21'h4);
    chk("pad_out", general_io_pin_o & 21'h4, 21'h4);
    periph_own <= 21'h0;
    periph_oe <= 21'h0;
    tick(6);
    chk("pad_oe", general_io_pin_oe, 21'h4);
    chk("pin_state", pin_state, 32'h1ffffb);
    chk("periph_in", periph_in, 21'h1ffffb);
    chk("evt_status", evt_status, 32'h0);
    $display("test sharing done");
  endtask

  task automatic t_byte;
    byte_wr_grp <= gpwi_pkg::GPWI_GRP_HIGH;
    byte_wdata <= 8'ha5;
    pulse(3);
    tick(1);
    chk("out_value", out_value, 21'h00a500);
    byte_wr_grp <= gpwi_pkg::GPWI_GRP_LOW;
    byte_wdata <= 8'h5a;
    pulse(3);
    tick(1);
    chk("out_value", out_value, 21'h00a55a);
    dir_wdata <= 21'h00ff00;
    ext_drv <= 21'h0000ff;
    ext_val <= 21'h000038;
    pulse(0);
    tick(6);
    chk("byte_rdata", byte_rdata, 8'h38);
    chk("byte_grp_ok", byte_grp_ok, 1'b1);
    byte_rd_grp <= gpwi_pkg::GPWI_GRP_HIGH;
    tick(2);
    chk("byte_rdata", byte_rdata, 8'ha5);
    chk("byte_grp_ok", byte_grp_ok, 1'b0);
    $display("test byte done");
  endtask

  task automatic t_event;
    en_wdata <= 21'h8;
    edge_wdata <= 21'h10;
    pwr_state <= gpwi_pkg::GPWI_PWR_SLEEP;
    pulse(6);
    pulse(5);
    tick(1);
    chk("evt_cfg", evt_cfg, {21'h10, 21'h8});
    ext_val <= 21'h30;
    tick(6);
    chk("evt_status", evt_status, 32'h0);
    ext_val <= 21'h38;
    for (int i = 0; i < 10 && wake_req !== 1'b1; i++) tick(1);
    chk("wake_req", wake_req, 1'b1);
    if (wake_req !== 1'b1) report_and_stop();
    chk("evt_status", evt_status, 32'h8);
    tick(1);
    chk("sysctl_irq", sysctl_irq, 1'b1);
    ext_val <= 21'h28;
    tick(6);
    chk("evt_status", evt_status, 32'h18);
    status_clr <= 21'h8;
    tick(1);
    status_clr <= 21'h0;
    tick(2);
    chk("sysctl_irq", sysctl_irq, 1'b0);
    pulse(8);
    tick(1);
    chk("evt_status", evt_status, 32'h0);
    en_wdata <= 21'h0;
    pulse(7);
    tick(1);
    chk("evt_cfg", evt_cfg, {21'h10, 21'h0});
    edge_wdata <= 21'h0;
    pulse(4);
    tick(1);
    chk("evt_cfg", evt_cfg, 42'h0);
    $display("test event done");
  endtask

  task automatic t_pull;
    periph_own <= 21'h6;
    xtal_pin <= 21'h2;
    pull_wdata <= 21'h1ffff6;
    pwr_state <= gpwi_pkg::GPWI_PWR_DEEP;
    pulse(2);
    tick(4);
    chk("pad_pu", general_io_pin_pu, 21'h1ffff4);
    $display("test pull done");
  endtask

  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    tick(1);
    t_out();
    t_periph();
    t_byte();
    t_event();
    t_pull();
    report_and_stop();
  end
endmodule

bind gpwi_port gpwi_port_assertions gpwi_port_assertions_i (.*);

`default_nettype wire
